// ===== hw/mrtp_regs.sv
// Purpose: ring timer parameter registers with expansion and use
// Assumes: all inputs come from logic on mclk
// Notes: reads always allowed, writes only in stop mode
//
// Overview of operation
// - codes except negotiated time expand into 24-bit negative values
// - reads always allowed; writes take effect only in stop mode
// - priority request compares expanded threshold against holding timer
// - threshold upper four bits written and read as zero
// - threshold code n means 10.24 us times 2^n, default C
// - priority threshold users lowest; async bounded by target time
// - no frames transmitted while the late flag is set
// - max rotation upper bits ignored on write, read zero
// - max rotation code n means 40.96 us times 2^n
// - master reset loads max rotation code C
// - immediate request entering transmit data reloads rotation timer with max
// - valid transmission upper bits ignored, code means 40.96 us times 2^n
// - valid transmission value bounds wait for valid frame or token
// - master reset loads valid transmission code 6
// - negotiated time loaded from claim bid or host write
// - negotiated time top byte always all ones, 80 ns resolution
// - ring up loads rotation timer from negotiated time, no compare
// - master reset sets negotiated time to ffe00000
`timescale 1ns/10ps
`default_nettype none
module mrtp_regs
    import mrtp_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic master_reset_bit,
    input wire logic stop_mode,
    input wire logic [7:0] ctl_addr,
    input wire logic [7:0] ctl_wdata,
    input wire logic ctl_wr,
    input wire logic ctl_rd,
    output logic [7:0] ctl_rdata,
    output logic ctl_wr_refused,
    input wire logic claim_bid_valid,
    input wire logic [31:0] received_claim_bid,
    input wire logic ring_operational,
    input wire logic transmit_data_state,
    input wire logic immediate_req,
    input wire logic [23:0] token_holding_timer,
    input wire logic async_req,
    input wire logic async_prio_req,
    input wire logic late_flag,
    output logic [23:0] thsh_value,
    output logic [23:0] max_rotation_time_value,
    output logic [23:0] tvx_value,
    output logic [31:0] negotiated_rotation_time_value,
    output logic trt_load,
    output logic [23:0] trt_load_value,
    output mrtp_trt_src_e trt_load_src,
    output logic async_grant,
    output logic prio_grant,
    output logic tx_inhibit
);

    ////////////////////////////////////////////////////////////////////////
    // register storage and write qualification

    logic [3:0] thsh_code;
    logic [3:0] max_rotation_time_code;
    logic [3:0] tvx_code;
    logic [23:0] negotiated_rotation_time_low;
    logic [23:0] thsh_exp;
    logic [23:0] max_rotation_time_exp;
    logic [23:0] tvx_exp;
    logic wr_ok;
    logic ring_op_q;
    logic t2_q;
    logic ring_up;
    logic t2_entry;
    logic tht_live;
    logic prio_usable;
    logic [7:0] next_rdata;

    // true when a host access hits one of the negotiated time bytes
    function automatic logic is_negotiated_rotation_time(input logic [7:0] a);
        is_negotiated_rotation_time = (a >= MRTP_ADDR_TNEG0) && (a <= MRTP_ADDR_TNEG3);
    endfunction

    // writes outside stop mode are dropped by the bank and flagged on ctl_wr_refused
    assign wr_ok = ctl_wr && stop_mode;

    // threshold code, upper bits forced to zero by storing four bits only
    always_ff @(posedge mclk) begin
        if (!nrst || master_reset_bit) begin
            thsh_code <= MRTP_RST_THSH;
        end else if (wr_ok && ctl_addr == MRTP_ADDR_THSH) begin
            thsh_code <= ctl_wdata[3:0];
        end
    end

    // max rotation code
    always_ff @(posedge mclk) begin
        if (!nrst || master_reset_bit) begin
            max_rotation_time_code <= MRTP_RST_MAX_ROTATION_TIME;
        end else if (wr_ok && ctl_addr == MRTP_ADDR_MAX_ROTATION_TIME) begin
            max_rotation_time_code <= ctl_wdata[3:0];
        end
    end

    // valid transmission code
    always_ff @(posedge mclk) begin
        if (!nrst || master_reset_bit) begin
            tvx_code <= MRTP_RST_TVX;
        end else if (wr_ok && ctl_addr == MRTP_ADDR_TVX) begin
            tvx_code <= ctl_wdata[3:0];
        end
    end

    // negotiated time, three writable bytes; the top byte is a constant.
    // a claim bid wins over a host write in the same cycle, since the
    // ring outcome must not be lost to a stale software value
    generate
        for (genvar b = 0; b < 3; b++) begin : g_negotiated_rotation_time
            localparam logic [7:0] BYTE_ADDR = MRTP_ADDR_TNEG3 - 8'(b);
            always_ff @(posedge mclk) begin
                if (!nrst || master_reset_bit) begin
                    negotiated_rotation_time_low[8*b +: 8] <= MRTP_RST_NEGOTIATED_ROTATION_TIME[8*b +: 8];
                end else if (claim_bid_valid) begin
                    negotiated_rotation_time_low[8*b +: 8] <= received_claim_bid[8*b +: 8];
                end else if (wr_ok && ctl_addr == BYTE_ADDR) begin
                    negotiated_rotation_time_low[8*b +: 8] <= ctl_wdata;
                end
            end
        end
    endgenerate

    // refused write flag, one cycle after a write outside stop mode
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctl_wr_refused <= 1'b0;
        end else begin
            ctl_wr_refused <= ctl_wr && !stop_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path

    // unused upper nibbles read as zero, unmapped reads give zero
    always_comb begin
        next_rdata = MRTP_RD_UNMAPPED;
        if (ctl_addr == MRTP_ADDR_THSH) begin
            next_rdata = {MRTP_UPPER_ZERO, thsh_code};
        end else if (ctl_addr == MRTP_ADDR_MAX_ROTATION_TIME) begin
            next_rdata = {MRTP_UPPER_ZERO, max_rotation_time_code};
        end else if (ctl_addr == MRTP_ADDR_TVX) begin
            next_rdata = {MRTP_UPPER_ZERO, tvx_code};
        end else if (is_negotiated_rotation_time(ctl_addr)) begin
            next_rdata = 8'({MRTP_NEGOTIATED_ROTATION_TIME_TOP, negotiated_rotation_time_low} >> (8 * int'(MRTP_ADDR_TNEG3 - ctl_addr)));
        end
    end

    // reads are honoured in any mode
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctl_rdata <= MRTP_RD_UNMAPPED;
        end else if (ctl_rd) begin
            ctl_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // expansion into timer counts

    mrtp_expand #(.BASE_SHIFT(MRTP_SHIFT_10US)) u_thsh_exp (
        .code(thsh_code),
        .value(thsh_exp)
    );

    mrtp_expand #(.BASE_SHIFT(MRTP_SHIFT_40US)) u_max_rotation_time_exp (
        .code(max_rotation_time_code),
        .value(max_rotation_time_exp)
    );

    mrtp_expand #(.BASE_SHIFT(MRTP_SHIFT_40US)) u_tvx_exp (
        .code(tvx_code),
        .value(tvx_exp)
    );

    // expanded values to the timer logic, one cycle behind the codes
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            thsh_value <= 24'h000000;
            max_rotation_time_value <= 24'h000000;
            tvx_value <= 24'h000000;
            negotiated_rotation_time_value <= MRTP_RST_NEGOTIATED_ROTATION_TIME;
        end else begin
            thsh_value <= thsh_exp;
            max_rotation_time_value <= max_rotation_time_exp;
            tvx_value <= tvx_exp;
            negotiated_rotation_time_value <= {MRTP_NEGOTIATED_ROTATION_TIME_TOP, negotiated_rotation_time_low};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // token rotation timer reloads

    assign ring_up = ring_operational && !ring_op_q;
    assign t2_entry = transmit_data_state && !t2_q && immediate_req;

    // edge history of ring state and transmit state
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ring_op_q <= 1'b0;
            t2_q <= 1'b0;
        end else begin
            ring_op_q <= ring_operational;
            t2_q <= transmit_data_state;
        end
    end

    // ring up takes precedence; no check against the requested time
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            trt_load <= 1'b0;
            trt_load_value <= 24'h000000;
            trt_load_src <= TRT_SRC_NONE;
        end else if (ring_up) begin
            trt_load <= 1'b1;
            trt_load_value <= negotiated_rotation_time_low;
            trt_load_src <= TRT_SRC_NEGOTIATED_ROTATION_TIME;
        end else if (t2_entry) begin
            trt_load <= 1'b1;
            trt_load_value <= max_rotation_time_exp;
            trt_load_src <= TRT_SRC_MAX_ROTATION_TIME;
        end else begin
            trt_load <= 1'b0;
            trt_load_src <= TRT_SRC_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // asynchronous transmit gating

    // holding timer is negative while time remains within the target time
    assign tht_live = token_holding_timer[23];
    // more remaining than the threshold means a more negative count
    assign prio_usable = $signed(token_holding_timer) < $signed(thsh_exp);

    // late flag vetoes everything; plain requests beat priority ones
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            async_grant <= 1'b0;
            prio_grant <= 1'b0;
            tx_inhibit <= 1'b0;
        end else begin
            tx_inhibit <= late_flag;
            async_grant <= !late_flag && async_req && tht_live;
            prio_grant <= !late_flag && async_prio_req && !async_req
                && tht_live && prio_usable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_locked_codes: assert property (
        !stop_mode && !master_reset_bit |=> $stable(thsh_code) && $stable(max_rotation_time_code)
            && $stable(tvx_code))
        else $error("timer code changed outside stop mode");

    a_locked_negotiated_rotation_time: assert property (
        !stop_mode && !master_reset_bit && !claim_bid_valid |=> $stable(negotiated_rotation_time_low))
        else $error("negotiated time changed without a source");

    a_thsh_write: assert property (
        wr_ok && !master_reset_bit && ctl_addr == MRTP_ADDR_THSH
            |=> thsh_code == $past(ctl_wdata[3:0]))
        else $error("threshold write not taken");

    a_upper_zero: assert property (
        ctl_rd && (ctl_addr == MRTP_ADDR_THSH || ctl_addr == MRTP_ADDR_MAX_ROTATION_TIME
            || ctl_addr == MRTP_ADDR_TVX) |=> ctl_rdata[7:4] == MRTP_UPPER_ZERO)
        else $error("upper nibble not zero");

    a_negotiated_rotation_time_top: assert property (
        ctl_rd && ctl_addr == MRTP_ADDR_TNEG0 |=> ctl_rdata == MRTP_NEGOTIATED_ROTATION_TIME_TOP)
        else $error("negotiated top byte not all ones");

    a_mreset_load: assert property (
        master_reset_bit |=> max_rotation_time_code == MRTP_RST_MAX_ROTATION_TIME && tvx_code == MRTP_RST_TVX
            && thsh_code == MRTP_RST_THSH ##1 negotiated_rotation_time_value == MRTP_RST_NEGOTIATED_ROTATION_TIME)
        else $error("master reset defaults wrong");

    a_max_rotation_time_expand: assert property (
        1'b1 |=> max_rotation_time_value == 24'(25'h0 - (25'h1 << (MRTP_SHIFT_40US
            + {1'b0, $past(max_rotation_time_code)}))))
        else $error("max rotation expansion wrong");

    a_thsh_expand: assert property (
        1'b1 |=> thsh_value == 24'(25'h0 - (25'h1 << (MRTP_SHIFT_10US
            + {1'b0, $past(thsh_code)}))))
        else $error("threshold expansion wrong");

    a_tvx_expand: assert property (
        1'b1 |=> tvx_value == 24'(25'h0 - (25'h1 << (MRTP_SHIFT_40US
            + {1'b0, $past(tvx_code)}))))
        else $error("valid transmission expansion wrong");

    a_ring_up_load: assert property (
        ring_operational && !ring_op_q |=> trt_load && trt_load_src == TRT_SRC_NEGOTIATED_ROTATION_TIME
            && trt_load_value == $past(negotiated_rotation_time_low) ##1 !trt_load || $past(t2_entry))
        else $error("ring up reload wrong");

    a_t2_load: assert property (
        t2_entry && !ring_up |=> trt_load && trt_load_src == TRT_SRC_MAX_ROTATION_TIME
            && trt_load_value == $past(max_rotation_time_exp))
        else $error("transmit data reload wrong");

    a_late_block: assert property (
        late_flag |=> tx_inhibit && !async_grant && !prio_grant)
        else $error("transmit allowed while late");

    a_prio_lowest: assert property (
        async_req || !tht_live |=> !prio_grant)
        else $error("priority grant not lowest");

    a_prio_compare: assert property (
        async_prio_req && !async_req && !late_flag && tht_live
            |=> prio_grant == $past(prio_usable))
        else $error("priority compare wrong");

    a_claim_load: assert property (
        claim_bid_valid && !master_reset_bit
            |=> negotiated_rotation_time_low == $past(received_claim_bid[23:0]))
        else $error("claim bid not loaded");

    c_ring_up: cover property (ring_up ##1 trt_load);
    c_t2_load: cover property (t2_entry && !ring_up ##1 trt_load);
    c_prio_grant: cover property (prio_grant);
    c_refused: cover property (ctl_wr_refused);

endmodule // mrtp_regs
`default_nettype wire

// ===== hw/mrtp_pkg.sv
// Purpose: shared constants for the ring timer parameter bank
// Assumes: 8-bit control interface, timers count in 80 ns units
// Notes: all timer values are negative two's complement counts
package mrtp_pkg;

    // control interface byte addresses
    localparam logic [7:0] MRTP_ADDR_THSH = 8'h87;
    localparam logic [7:0] MRTP_ADDR_MAX_ROTATION_TIME = 8'h93;
    localparam logic [7:0] MRTP_ADDR_TVX = 8'h97;
    localparam logic [7:0] MRTP_ADDR_TNEG0 = 8'h98;
    localparam logic [7:0] MRTP_ADDR_TNEG3 = 8'h9b;

    // master reset defaults
    localparam logic [3:0] MRTP_RST_THSH = 4'hc;
    localparam logic [3:0] MRTP_RST_MAX_ROTATION_TIME = 4'hc;
    localparam logic [3:0] MRTP_RST_TVX = 4'h6;
    localparam logic [31:0] MRTP_RST_NEGOTIATED_ROTATION_TIME = 32'hffe00000;

    // field layout
    localparam logic [7:0] MRTP_NEGOTIATED_ROTATION_TIME_TOP = 8'hff;
    localparam logic [3:0] MRTP_UPPER_ZERO = 4'h0;
    localparam logic [7:0] MRTP_RD_UNMAPPED = 8'h00;

    // timer resolution and code bases, as exponents of the 80 ns unit
    localparam int MRTP_TIMER_RES_NS = 80;
    localparam int MRTP_BASE_10US_NS = 10240;
    localparam int MRTP_BASE_40US_NS = 40960;
    localparam logic [4:0] MRTP_SHIFT_10US = 5'h07;
    localparam logic [4:0] MRTP_SHIFT_40US = 5'h09;

    // source of a token rotation timer reload
    typedef enum logic [1:0] {
        TRT_SRC_NONE = 2'b00,
        TRT_SRC_MAX_ROTATION_TIME = 2'b01,
        TRT_SRC_NEGOTIATED_ROTATION_TIME = 2'b10
    } mrtp_trt_src_e;

endpackage

// ===== hw/mrtp_expand.sv
// Purpose: exponential expansion of a 4-bit timer code
// Assumes: result is a 24-bit negative count of 80 ns units
// Notes: code giving 2^24 wraps to zero, i.e. a full timer span
`timescale 1ns/10ps
`default_nettype none
module mrtp_expand
    import mrtp_pkg::*;
#(
    parameter logic [4:0] BASE_SHIFT = MRTP_SHIFT_40US
) (
    input wire logic [3:0] code,
    output logic [23:0] value
);

    logic [24:0] mag;

    // magnitude is 2^(base+code), negated in two's complement
    always_comb begin
        mag = 25'h0000001 << (BASE_SHIFT + {1'b0, code});
        value = 24'(25'h0000000 - mag);
    end

endmodule // mrtp_expand
`default_nettype wire

// ===== testbench/mrtp_host.sv
// Purpose: host software model on the control interface
// Assumes: byte interface synchronous to mclk, one access per wr_reg or rd_reg call
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module mrtp_host
    import mrtp_pkg::*;
(
    input wire logic mclk,
    input wire logic [7:0] ctl_rdata,
    output logic stop_mode,
    output logic [7:0] ctl_addr,
    output logic [7:0] ctl_wdata,
    output logic ctl_wr,
    output logic ctl_rd
);
    // idle bus, controller stopped so setup writes land
    initial begin
        stop_mode = 1'b1;
        ctl_addr = 8'h00;
        ctl_wdata = 8'h00;
        ctl_wr = 1'b0;
        ctl_rd = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // stop mode gates every write
    task automatic set_stop(input logic s);
        @(posedge mclk);
        stop_mode <= s;
    endtask
    // strobe held one cycle, released only after the sampling edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        ctl_addr <= a;
        ctl_wdata <= d;
        ctl_wr <= 1'b1;
        @(posedge mclk);
        ctl_wr <= 1'b0;
        ctl_addr <= ~a;
        ctl_wdata <= ~d;
    endtask
    // registered read data lands just after the sampling edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        ctl_addr <= a;
        ctl_rd <= 1'b1;
        @(posedge mclk);
        ctl_rd <= 1'b0;
        ctl_addr <= ~a;
        #1 d = ctl_rdata;
    endtask
    // management reset: negotiated time takes max rotation, no early claim
    task automatic load_negotiated_rotation_time_max(input logic [23:0] v);
        wr_reg(MRTP_ADDR_TNEG3 - 8'h02, v[23:16]);
        wr_reg(MRTP_ADDR_TNEG3 - 8'h01, v[15:8]);
        wr_reg(MRTP_ADDR_TNEG3, v[7:0]);
    endtask
endmodule // mrtp_host
`default_nettype wire

// ===== testbench/tb_mac_ring_timer_parameters.sv
// Purpose: self-checking bench for the ring timer parameter bank
// Assumes: host model drives the control interface
// Notes: random values from a fixed xorshift seed
`timescale 1ns/10ps
`default_nettype none
module tb_mac_ring_timer_parameters
    import mrtp_pkg::*;
;
    logic mclk, nrst, master_reset_bit, stop_mode, ctl_wr, ctl_rd, ctl_wr_refused;
    logic [7:0] ctl_addr, ctl_wdata, ctl_rdata, a, d;
    logic claim_bid_valid, ring_operational, transmit_data_state, immediate_req;
    logic async_req, async_prio_req, late_flag, trt_load, async_grant, prio_grant, tx_inhibit;
    logic [31:0] received_claim_bid, negotiated_rotation_time_value, seed, r;
    logic [23:0] token_holding_timer, thsh_value, max_rotation_time_value, tvx_value, trt_load_value, got;
    logic [3:0] code [0:2];
    logic [7:0] ra [0:2];
    logic [4:0] base;
    mrtp_trt_src_e trt_load_src;
    int errors, samples_checked;
    mrtp_regs dut (.mclk(mclk), .nrst(nrst), .master_reset_bit(master_reset_bit),
        .stop_mode(stop_mode), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata), .ctl_wr(ctl_wr),
        .ctl_rd(ctl_rd), .ctl_rdata(ctl_rdata), .ctl_wr_refused(ctl_wr_refused),
        .claim_bid_valid(claim_bid_valid), .received_claim_bid(received_claim_bid),
        .ring_operational(ring_operational), .transmit_data_state(transmit_data_state),
        .immediate_req(immediate_req), .token_holding_timer(token_holding_timer),
        .async_req(async_req), .async_prio_req(async_prio_req), .late_flag(late_flag),
        .thsh_value(thsh_value), .max_rotation_time_value(max_rotation_time_value), .tvx_value(tvx_value),
        .negotiated_rotation_time_value(negotiated_rotation_time_value), .trt_load(trt_load), .trt_load_value(trt_load_value),
        .trt_load_src(trt_load_src), .async_grant(async_grant), .prio_grant(prio_grant),
        .tx_inhibit(tx_inhibit));
    mrtp_host host (.mclk(mclk), .ctl_rdata(ctl_rdata), .stop_mode(stop_mode),
        .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd));
    ////////////////////////////////////////////////////////////////
    // 100 ns clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // negative count of 80 ns units; 2^24 wraps to a full span
    function automatic logic [23:0] expand(input logic [3:0] n, input logic [4:0] b);
        return 24'(-(33'd1 << (b + n)));
    endfunction
    task automatic close_out();
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk8(input string w, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chkv(input string w, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk1(input string w, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %b seen %b", w, e, g);
        end
    endtask
    task automatic rdchk(input logic [7:0] ad, input logic [7:0] e);
        logic [7:0] v;
        host.rd_reg(ad, v);
        chk8("ctl_rdata", e, v);
    endtask
    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        errors = 0;
        samples_checked = 0;
        seed = 32'd98722;
        ra[0] = MRTP_ADDR_THSH;
        ra[1] = MRTP_ADDR_MAX_ROTATION_TIME;
        ra[2] = MRTP_ADDR_TVX;
        {nrst, master_reset_bit, claim_bid_valid, ring_operational} = 4'h0;
        {transmit_data_state, immediate_req, async_req, async_prio_req, late_flag} = 5'h00;
        received_claim_bid = 32'h0;
        token_holding_timer = 24'h0;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        rdchk(MRTP_ADDR_THSH, 8'h0c);
        rdchk(MRTP_ADDR_MAX_ROTATION_TIME, 8'h0c);
        rdchk(MRTP_ADDR_TVX, 8'h06);
        rdchk(MRTP_ADDR_TNEG0, 8'hff);
        rdchk(8'h99, 8'he0);
        rdchk(8'h86, 8'h00);
        chkv("negotiated_rotation_time_value", 32'hffe00000, negotiated_rotation_time_value);
        // code writes: all-ones corner first, then random bytes
        for (int i = 0; i < 15; i++) begin
            r = xs();
            d = (i < 3) ? 8'hff : r[7:0];
            a = ra[i % 3];
            code[i % 3] = d[3:0];
            host.wr_reg(a, d);
            #1 chk1("ctl_wr_refused", 1'b0, ctl_wr_refused);
            rdchk(a, {4'h0, d[3:0]});
            base = (i % 3 == 0) ? MRTP_SHIFT_10US : MRTP_SHIFT_40US;
            got = (i % 3 == 0) ? thsh_value : (i % 3 == 1) ? max_rotation_time_value : tvx_value;
            chkv("expanded", {8'h0, expand(d[3:0], base)}, {8'h0, got});
        end
        // write outside stop mode is refused and changes nothing
        host.set_stop(1'b0);
        host.wr_reg(MRTP_ADDR_MAX_ROTATION_TIME, ~{4'h0, code[1]});
        #1 chk1("ctl_wr_refused", 1'b1, ctl_wr_refused);
        rdchk(MRTP_ADDR_MAX_ROTATION_TIME, {4'h0, code[1]});
        host.set_stop(1'b1);
        // negotiated time bytes; top byte stays all ones
        r = xs();
        host.wr_reg(8'h99, r[23:16]);
        host.wr_reg(8'h9a, r[15:8]);
        host.wr_reg(8'h9b, r[7:0]);
        host.wr_reg(MRTP_ADDR_TNEG0, 8'h00);
        rdchk(MRTP_ADDR_TNEG0, 8'hff);
        chkv("negotiated_rotation_time_value", {8'hff, r[23:0]}, negotiated_rotation_time_value);
        // claim bid load, top byte of the bid ignored
        r = xs();
        @(posedge mclk);
        received_claim_bid <= {~r[31:24], r[23:0]};
        claim_bid_valid <= 1'b1;
        @(posedge mclk);
        claim_bid_valid <= 1'b0;
        @(posedge mclk);
        #1 chkv("negotiated_rotation_time_value", {8'hff, r[23:0]}, negotiated_rotation_time_value);
        // ring up reloads rotation timer from negotiated time
        @(posedge mclk);
        ring_operational <= 1'b1;
        @(posedge mclk);
        #1 chk1("trt_load", 1'b1, trt_load);
        chkv("trt_src", 32'h2, {30'h0, trt_load_src});
        chkv("trt_value", {8'h0, r[23:0]}, {8'h0, trt_load_value});
        rdchk(8'h99, r[23:16]);
        // immediate request entering transmit data reloads with max rotation
        @(posedge mclk);
        immediate_req <= 1'b1;
        transmit_data_state <= 1'b1;
        @(posedge mclk);
        #1 chkv("trt_src", 32'h1, {30'h0, trt_load_src});
        chkv("trt_value", {8'h0, expand(code[1], 5'h09)}, {8'h0, trt_load_value});
        @(posedge mclk);
        #1 chk1("trt_load", 1'b0, trt_load);
        // management reset by the host, after a standard max rotation
        host.wr_reg(MRTP_ADDR_MAX_ROTATION_TIME, 8'h0c);
        host.load_negotiated_rotation_time_max(expand(4'hc, 5'h09));
        @(posedge mclk);
        #1 chkv("negotiated_rotation_time_value", 32'hffe00000, negotiated_rotation_time_value);
        // host picks a threshold that suits the negotiated time
        host.wr_reg(MRTP_ADDR_THSH, 8'h0c);
        for (int i = 0; i < 40; i++) begin
            r = xs();
            @(posedge mclk);
            token_holding_timer <= r[28] ? {4'hf, r[19:0]} : r[23:0];
            async_req <= r[24];
            async_prio_req <= r[25];
            late_flag <= r[26] & r[27];
            @(posedge mclk);
            #1 got = token_holding_timer;
            chk1("async_grant", !late_flag & async_req & got[23], async_grant);
            chk1("prio_grant", !late_flag & async_prio_req & !async_req & got[23]
                & ($signed(got) < $signed(expand(4'hc, 5'h07))), prio_grant);
            chk1("tx_inhibit", late_flag, tx_inhibit);
        end
        // move max rotation and threshold codes and negotiated time off their defaults first; valid transmission code is not rewritten
        host.wr_reg(MRTP_ADDR_MAX_ROTATION_TIME, 8'h03);
        host.wr_reg(MRTP_ADDR_THSH, 8'h01);
        host.wr_reg(8'h9b, 8'h5a);
        // master reset restores every default
        @(posedge mclk);
        master_reset_bit <= 1'b1;
        @(posedge mclk);
        master_reset_bit <= 1'b0;
        rdchk(MRTP_ADDR_TVX, 8'h06);
        rdchk(MRTP_ADDR_MAX_ROTATION_TIME, 8'h0c);
        rdchk(MRTP_ADDR_THSH, 8'h0c);
        chkv("negotiated_rotation_time_value", 32'hffe00000, negotiated_rotation_time_value);
        close_out();
    end
endmodule // tb_mac_ring_timer_parameters
`default_nettype wire
